// ---- acc_ctrl.sv ----
// analog comparator control: sync, input select, edge events, registers
//
// Overview of operation
// RULE1 - result high when positive input exceeds negative
// RULE2 - raw output synchronised, one to two cycles
// RULE3 - disable bit seven powers comparator down
// RULE4 - bandgap select replaces positive pin input
// RULE5 - flag set on transition matching mode
// RULE6 - irq requested when flag, enable, global set
// RULE7 - vector execution clears the event flag
// RULE8 - writing one clears flag, zero keeps
// RULE9 - capture route feeds result to timer
// RULE10 - mode: toggle, reserved, falling, rising
// RULE11 - software disables irq before mode change
// RULE12 - software disables irq before power change
// RULE13 - mux enable, converter off: channel negative
// RULE14 - otherwise dedicated negative pin used
// RULE15 - buffer off pin reads as zero
// RULE16 - converter on blocks multiplexer path
// RULE17 - edges found against previous cycle value
// RULE18 - reserved mode never sets the flag
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`include "acc_params.svh"
module acc_ctrl (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire acc_pkg::acc_avs_req_s i_avs,
  output logic o_avs_waitrequest,
  output logic [31:0] o_avs_readdata,
  input wire logic i_cmp_raw,
  input wire logic i_pos_pin_din,
  input wire logic i_neg_pin_din,
  input wire logic i_converter_on,
  input wire logic [2:0] i_channel_select,
  input wire logic i_global_irq_enable,
  input wire logic i_irq_vector_ack,
  output logic o_cmp_power_off,
  output logic o_bandgap_positive_select,
  output acc_pkg::acc_neg_sel_s o_neg_sel,
  output logic o_pos_pin_buffer_off,
  output logic o_neg_pin_buffer_off,
  output logic o_pos_pin_port_bit,
  output logic o_neg_pin_port_bit,
  output logic o_capture_input,
  output logic o_cmp_irq,
  output logic o_sys_irq
);
  import acc_pkg::*;

  acc_bus_state_e bus_state_reg;
  logic mux_en_reg;
  logic pwr_off_reg;
  logic bg_sel_reg;
  logic flag_reg;
  logic irq_en_reg;
  logic capt_reg;
  logic [1:0] mode_reg;
  logic [1:0] pin_dis_reg;
  logic [1:0] stat_reg;
  logic [1:0] mask_reg;
  logic [1:0] cmp_sync_reg;
  logic [1:0] pos_sync_reg;
  logic [1:0] neg_sync_reg;
  logic prev_reg;
  logic result;
  logic rise;
  logic fall;
  logic event_hit;
  logic acc_wr;
  logic acc_rd;
  logic [7:0] csr_val;
  logic [31:0] rd_next;

  ////////////////////////////////////////////////////////////////////////
  // synchronisers; bit 0 is the first flop and only feeds bit 1
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cmp_sync_reg <= `ACC_RST_SYNC;
      pos_sync_reg <= `ACC_RST_SYNC;
      neg_sync_reg <= `ACC_RST_SYNC;
    end else begin
      cmp_sync_reg <= {cmp_sync_reg[0], i_cmp_raw}; // RULE2
      pos_sync_reg <= {pos_sync_reg[0], i_pos_pin_din};
      neg_sync_reg <= {neg_sync_reg[0], i_neg_pin_din};
    end
  end

  // a powered-down comparator reads low; the step it makes is a real edge,
  // which is why software must mask the irq around a power change
  assign result = cmp_sync_reg[1] & ~pwr_off_reg; // RULE1
  assign rise = result & ~prev_reg; // RULE17
  assign fall = ~result & prev_reg; // RULE17

  // event decode per interrupt mode
  always_comb begin
    case (mode_reg) // RULE10
      `ACC_MODE_TOGGLE: event_hit = rise | fall;
      `ACC_MODE_FALL: event_hit = fall;
      `ACC_MODE_RISE: event_hit = rise;
      default: event_hit = 1'b0; // RULE18
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev_reg <= `ACC_RST_BIT;
    end else begin
      prev_reg <= result; // RULE17
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then the answer edge
  assign acc_wr = i_avs.write & ~o_avs_waitrequest;
  assign acc_rd = i_avs.read & ~o_avs_waitrequest;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bus_state_reg <= ACC_BUS_IDLE;
      o_avs_waitrequest <= 1'b1;
    end else begin
      case (bus_state_reg)
        ACC_BUS_IDLE: begin
          if (i_avs.read | i_avs.write) begin
            bus_state_reg <= ACC_BUS_ANSWER;
            o_avs_waitrequest <= 1'b0;
          end
        end
        ACC_BUS_ANSWER: begin
          bus_state_reg <= ACC_BUS_IDLE;
          o_avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_state_reg <= ACC_BUS_IDLE;
          o_avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  assign csr_val = {pwr_off_reg, bg_sel_reg, result, flag_reg,
                    irq_en_reg, capt_reg, mode_reg};

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_next = `ACC_RST_DATA;
    case (i_avs.address)
      `ACC_OFS_CONV_B: rd_next[`ACC_BIT_MUX_EN] = mux_en_reg;
      `ACC_OFS_CSR: rd_next[7:0] = csr_val;
      `ACC_OFS_PIN_DIS: rd_next[1:0] = pin_dis_reg;
      `ACC_OFS_IRQ_STAT: rd_next[1:0] = stat_reg;
      `ACC_OFS_IRQ_MASK: rd_next[1:0] = mask_reg;
      default: rd_next = `ACC_RST_DATA;
    endcase
  end

  // data is captured as waitrequest drops, so it stands at the answer edge
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_avs_readdata <= `ACC_RST_DATA;
    end else if (bus_state_reg == ACC_BUS_IDLE && i_avs.read) begin
      o_avs_readdata <= rd_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers written by software
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mux_en_reg <= `ACC_RST_BIT;
      pwr_off_reg <= `ACC_RST_BIT;
      bg_sel_reg <= `ACC_RST_BIT;
      irq_en_reg <= `ACC_RST_BIT;
      capt_reg <= `ACC_RST_BIT;
      mode_reg <= `ACC_RST_MODE;
      pin_dis_reg <= `ACC_RST_STAT;
      mask_reg <= `ACC_RST_STAT;
    end else if (acc_wr) begin
      case (i_avs.address)
        `ACC_OFS_CONV_B: mux_en_reg <= i_avs.writedata[`ACC_BIT_MUX_EN];
        `ACC_OFS_CSR: begin
          pwr_off_reg <= i_avs.writedata[`ACC_BIT_PWR_OFF]; // RULE3
          bg_sel_reg <= i_avs.writedata[`ACC_BIT_BG_SEL]; // RULE4
          irq_en_reg <= i_avs.writedata[`ACC_BIT_IRQ_EN];
          capt_reg <= i_avs.writedata[`ACC_BIT_CAPT];
          mode_reg <= i_avs.writedata[`ACC_BIT_MODE_HI:`ACC_BIT_MODE_LO];
        end
        `ACC_OFS_PIN_DIS: pin_dis_reg <= i_avs.writedata[1:0];
        `ACC_OFS_IRQ_MASK: mask_reg <= i_avs.writedata[1:0];
        default: mux_en_reg <= mux_en_reg;
      endcase
    end
  end

  // event flag: a new event wins over any clear in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flag_reg <= `ACC_RST_BIT;
    end else if (event_hit) begin
      flag_reg <= 1'b1; // RULE5
    end else if (i_irq_vector_ack) begin
      flag_reg <= 1'b0; // RULE7
    end else if (acc_wr && i_avs.address == `ACC_OFS_CSR &&
                 i_avs.writedata[`ACC_BIT_FLAG]) begin
      flag_reg <= 1'b0; // RULE8
    end
  end
  // sticky status; a read clears only the bits it returned, so an event
  // caught while the read was in flight is not lost; new events win
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stat_reg <= `ACC_RST_STAT;
    end else begin
      stat_reg <= ((acc_rd && i_avs.address == `ACC_OFS_IRQ_STAT) ?
                   stat_reg & ~o_avs_readdata[1:0] : stat_reg) |
                  {rise | fall, event_hit};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs towards the analog front end, timer and core
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cmp_power_off <= `ACC_RST_BIT;
      o_bandgap_positive_select <= `ACC_RST_BIT;
      o_neg_sel <= '0;
      o_pos_pin_buffer_off <= `ACC_RST_BIT;
      o_neg_pin_buffer_off <= `ACC_RST_BIT;
      o_capture_input <= `ACC_RST_BIT;
      o_cmp_irq <= `ACC_RST_BIT;
      o_sys_irq <= `ACC_RST_BIT;
    end else begin
      o_cmp_power_off <= pwr_off_reg; // RULE3
      o_bandgap_positive_select <= bg_sel_reg; // RULE4
      // the converter owns the channel mux while it is on
      o_neg_sel.use_mux <= mux_en_reg & ~i_converter_on; // RULE13 RULE16
      o_neg_sel.channel <= (mux_en_reg & ~i_converter_on) ?
                           i_channel_select : `ACC_RST_CHAN; // RULE14
      o_pos_pin_buffer_off <= pin_dis_reg[`ACC_BIT_POS_DIS]; // RULE15
      o_neg_pin_buffer_off <= pin_dis_reg[`ACC_BIT_NEG_DIS]; // RULE15
      o_capture_input <= capt_reg & result; // RULE9
      o_cmp_irq <= flag_reg & irq_en_reg & i_global_irq_enable; // RULE6
      o_sys_irq <= |(stat_reg & mask_reg);
    end
  end

  // port bits read zero while the pin buffer is off
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pos_pin_port_bit <= `ACC_RST_BIT;
      o_neg_pin_port_bit <= `ACC_RST_BIT;
    end else begin
      o_pos_pin_port_bit <= pos_sync_reg[1] &
                            ~pin_dis_reg[`ACC_BIT_POS_DIS]; // RULE15
      o_neg_pin_port_bit <= neg_sync_reg[1] &
                            ~pin_dis_reg[`ACC_BIT_NEG_DIS]; // RULE15
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  sequence s_powered3;
    !pwr_off_reg [*3];
  endsequence
  property p_sync;
    s_powered3 |-> result == $past(i_cmp_raw, 2);
  endproperty
  a_sync: assert property (p_sync) // RULE2
    else $error("result not raw input two cycles late");

  property p_rise;
    (mode_reg == `ACC_MODE_RISE && rise) |=> flag_reg;
  endproperty
  a_rise: assert property (p_rise) // RULE5
    else $error("rising event did not set flag");

  property p_fall_only;
    (mode_reg == `ACC_MODE_FALL && rise && !fall && !flag_reg &&
     !acc_wr) |=> !flag_reg;
  endproperty
  a_fall_only: assert property (p_fall_only) // RULE10
    else $error("falling mode set flag on rise");

  property p_rsvd;
    (mode_reg == `ACC_MODE_RSVD && !flag_reg) |=> !flag_reg;
  endproperty
  a_rsvd: assert property (p_rsvd) // RULE18
    else $error("reserved mode set flag");

  property p_irq;
    1'b1 |=> o_cmp_irq ==
      $past(flag_reg & irq_en_reg & i_global_irq_enable);
  endproperty
  a_irq: assert property (p_irq) // RULE6
    else $error("irq request not flag and enables");

  property p_vec;
    (i_irq_vector_ack && !event_hit) |=> !flag_reg;
  endproperty
  a_vec: assert property (p_vec) // RULE7
    else $error("vector did not clear flag");

  sequence s_csr_write;
    acc_wr && i_avs.address == `ACC_OFS_CSR;
  endsequence
  property p_w0_keeps;
    (s_csr_write and (flag_reg && !i_avs.writedata[`ACC_BIT_FLAG] &&
     !i_irq_vector_ack)) |=> flag_reg;
  endproperty
  a_w0_keeps: assert property (p_w0_keeps) // RULE8
    else $error("write zero changed flag");

  property p_capt;
    1'b1 |=> o_capture_input == $past(capt_reg & result);
  endproperty
  a_capt: assert property (p_capt) // RULE9
    else $error("capture route wrong");

  property p_negsel;
    1'b1 |=> o_neg_sel.use_mux == $past(mux_en_reg & ~i_converter_on);
  endproperty
  a_negsel: assert property (p_negsel) // RULE13
    else $error("negative input select wrong");

  property p_pin_off;
    pin_dis_reg[`ACC_BIT_POS_DIS] |=> !o_pos_pin_port_bit;
  endproperty
  a_pin_off: assert property (p_pin_off) // RULE15
    else $error("disabled pin read nonzero");

  sequence s_bus_req;
    (i_avs.read || i_avs.write) && o_avs_waitrequest &&
    bus_state_reg == ACC_BUS_IDLE;
  endsequence
  property p_bus;
    s_bus_req |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus answer not one cycle after request");
endmodule

// ---- acc_ctrl_test.sv ----
// self-checking testbench of the analog comparator control block
`timescale 1ns/100ps
`include "acc_params.svh"
module acc_ctrl_test;
  import acc_pkg::*;
  `define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
    err_total++; $display("wrong value %s exp %h got %h", nm, ex, got); \
    end end
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  acc_avs_req_s avs = '0;
  logic waitreq;
  logic [31:0] rdata;
  logic raw = 1'b0, pos_din = 1'b1, neg_din = 1'b1, conv_on = 1'b0;
  logic [2:0] chan = 3'h0;
  logic gie = 1'b0, vack = 1'b0;
  logic pwr_off, bg_sel, pos_off, neg_off, pos_bit, neg_bit;
  logic capt, cmp_irq, sys_irq;
  acc_neg_sel_s neg_sel;
  int err_total = 0, tests_run = 0, cyc = 0;
  logic [31:0] d;
  ////////////////////////////////////////////////////////////////////////
  acc_ctrl i_acc_ctrl (.i_clk_sys(clk), .i_rst_b(rst_b), .i_avs(avs),
    .o_avs_waitrequest(waitreq), .o_avs_readdata(rdata), .i_cmp_raw(raw),
    .i_pos_pin_din(pos_din), .i_neg_pin_din(neg_din),
    .i_converter_on(conv_on), .i_channel_select(chan),
    .i_global_irq_enable(gie), .i_irq_vector_ack(vack),
    .o_cmp_power_off(pwr_off), .o_bandgap_positive_select(bg_sel),
    .o_neg_sel(neg_sel), .o_pos_pin_buffer_off(pos_off),
    .o_neg_pin_buffer_off(neg_off), .o_pos_pin_port_bit(pos_bit),
    .o_neg_pin_port_bit(neg_bit), .o_capture_input(capt),
    .o_cmp_irq(cmp_irq), .o_sys_irq(sys_irq));
  // 25 MHz clock
  always #20 clk = ~clk;
  // a hang ends the run well past the expected length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one bus access; request held until waitrequest is sampled low, and only
  // the bench timeout ends a wait on a slave that never answers
  task bus(input int w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    avs <= '{read: (w == 0), write: (w != 0), address: a, writedata: wd};
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    d = rdata;
    avs <= '0;
  endtask
  task cyc_wait(input int n);
    repeat (n) @(posedge clk);
  endtask
  task set_raw(input logic v);
    @(posedge clk);
    raw <= v;
    cyc_wait(5);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_reset_map;
    bus(0, `ACC_OFS_CSR, 0);
    `CHK("csr rst", `ACC_RST_DATA, d)
    bus(0, `ACC_OFS_CONV_B, 0);
    `CHK("conv_b rst", `ACC_RST_DATA, d)
    bus(1, 8'h24, 32'h0000_00FF);
    bus(0, 8'h24, 0);
    `CHK("unmapped", `ACC_RST_DATA, d)
    set_raw(1'b1);
    bus(0, `ACC_OFS_CSR, 0);
    `CHK("result", 1'b1, d[`ACC_BIT_RESULT])
    set_raw(1'b0);
    $display("test reset_map done");
  endtask
  // every mode against a rise then a fall of the comparator
  task t_modes;
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      bus(1, `ACC_OFS_CSR, {27'h0, 1'b1, 2'h0, m});
      set_raw(1'b1);
      bus(0, `ACC_OFS_CSR, 0);
      `CHK("rise", m == 2'h3 || m == 2'h0, d[4])
      bus(1, `ACC_OFS_CSR, {27'h0, 1'b1, 2'h0, m});
      set_raw(1'b0);
      bus(0, `ACC_OFS_CSR, 0);
      `CHK("flag fall", m == 2'h2 || m == 2'h0, d[4])
      bus(1, `ACC_OFS_CSR, {27'h0, 1'b1, 2'h0, m});
    end
    $display("test modes done");
  endtask
  task t_irq_flag;
    bus(1, `ACC_OFS_CSR, 32'h0000_000B);
    @(posedge clk);
    gie <= 1'b1;
    set_raw(1'b1);
    `CHK("cmp_irq on", 1'b1, cmp_irq)
    @(posedge clk);
    gie <= 1'b0;
    cyc_wait(2);
    `CHK("cmp_irq gie", 1'b0, cmp_irq)
    bus(1, `ACC_OFS_CSR, 32'h0000_000B);
    bus(0, `ACC_OFS_CSR, 0);
    `CHK("flag keep", 1'b1, d[4])
    @(posedge clk);
    vack <= 1'b1;
    @(posedge clk);
    vack <= 1'b0;
    cyc_wait(2);
    bus(0, `ACC_OFS_CSR, 0);
    `CHK("flag vector", 1'b0, d[4])
    set_raw(1'b0);
    set_raw(1'b1);
    bus(1, `ACC_OFS_CSR, 32'h0000_001B);
    bus(0, `ACC_OFS_CSR, 0);
    `CHK("flag w1c", 1'b0, d[4])
    bus(1, `ACC_OFS_CSR, 32'h0000_0003);
    set_raw(1'b0);
    $display("test irq_flag done");
  endtask
  // sticky status, mask and the summary interrupt
  task t_status;
    bus(1, `ACC_OFS_CSR, 32'h0000_0010);
    bus(0, `ACC_OFS_IRQ_STAT, 0);
    bus(1, `ACC_OFS_IRQ_MASK, 0);
    set_raw(1'b1);
    `CHK("sys_irq masked", 1'b0, sys_irq)
    bus(1, `ACC_OFS_IRQ_MASK, 32'h0000_0001);
    cyc_wait(2);
    `CHK("sys_irq", 1'b1, sys_irq)
    bus(0, `ACC_OFS_IRQ_STAT, 0);
    `CHK("status", 32'h0000_0003, d)
    cyc_wait(2);
    `CHK("sys_irq clr", 1'b0, sys_irq)
    bus(0, `ACC_OFS_IRQ_STAT, 0);
    `CHK("status clr", 32'h0000_0000, d)
    $display("test status done");
  endtask
  task t_route_power;
    bus(1, `ACC_OFS_CSR, 32'h0000_0014);
    cyc_wait(3);
    `CHK("capt on", 1'b1, capt)
    set_raw(1'b0);
    `CHK("capt follow", 1'b0, capt)
    set_raw(1'b1);
    bus(1, `ACC_OFS_CSR, 32'h0000_0010);
    cyc_wait(3);
    `CHK("capt off", 1'b0, capt)
    set_raw(1'b0);
    bus(1, `ACC_OFS_CSR, 32'h0000_00D0);
    cyc_wait(2);
    `CHK("power off", 1'b1, pwr_off)
    `CHK("bandgap", 1'b1, bg_sel)
    bus(0, `ACC_OFS_CSR, 0);
    `CHK("csr back", 32'h0000_00C0, d)
    bus(1, `ACC_OFS_CSR, 32'h0000_0010);
    cyc_wait(2);
    `CHK("bandgap off", 1'b0, bg_sel)
    $display("test route_power done");
  endtask
  task t_neg_sel;
    bus(1, `ACC_OFS_CONV_B, 32'h0000_0040);
    for (int c = 0; c < 8; c++) begin
      @(posedge clk);
      chan <= c[2:0];
      conv_on <= 1'b0;
      cyc_wait(3);
      `CHK("mux sel", {1'b1, c[2:0]}, neg_sel)
      @(posedge clk);
      conv_on <= 1'b1;
      cyc_wait(3);
      `CHK("mux conv on", 4'h0, neg_sel)
    end
    bus(1, `ACC_OFS_CONV_B, 0);
    @(posedge clk);
    conv_on <= 1'b0;
    cyc_wait(3);
    `CHK("mux off", 4'h0, neg_sel)
    $display("test neg_sel done");
  endtask
  task t_pins;
    bus(1, `ACC_OFS_PIN_DIS, 32'h0000_00FD);
    cyc_wait(2);
    `CHK("pos bit", 1'b0, pos_bit)
    `CHK("neg bit", 1'b1, neg_bit)
    `CHK("bufs", 2'b01, {neg_off, pos_off})
    bus(0, `ACC_OFS_PIN_DIS, 0);
    `CHK("pin_dis", 32'h0000_0001, d)
    bus(1, `ACC_OFS_PIN_DIS, 32'h0000_0002);
    cyc_wait(2);
    `CHK("pins", 2'b01, {neg_bit, pos_bit})
    @(posedge clk);
    pos_din <= 1'b0;
    cyc_wait(4);
    `CHK("pos low", 1'b0, pos_bit)
    $display("test pins done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_reset_map();
    t_modes();
    t_irq_flag();
    t_status();
    t_route_power();
    t_neg_sel();
    t_pins();
    end_sim();
  end
endmodule

// ---- acc_params.svh ----
// register map, field positions, reset values and codes of the comparator
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH
`define ACC_ADDR_W 8
`define ACC_OFS_CONV_B 8'h00
`define ACC_OFS_CSR 8'h04
`define ACC_OFS_PIN_DIS 8'h08
`define ACC_OFS_IRQ_STAT 8'h0C
`define ACC_OFS_IRQ_MASK 8'h10
`define ACC_BIT_MUX_EN 6
`define ACC_BIT_PWR_OFF 7
`define ACC_BIT_BG_SEL 6
`define ACC_BIT_RESULT 5
`define ACC_BIT_FLAG 4
`define ACC_BIT_IRQ_EN 3
`define ACC_BIT_CAPT 2
`define ACC_BIT_MODE_HI 1
`define ACC_BIT_MODE_LO 0
`define ACC_BIT_NEG_DIS 1
`define ACC_BIT_POS_DIS 0
`define ACC_STAT_EVENT 0
`define ACC_STAT_TOGGLE 1
`define ACC_MODE_TOGGLE 2'h0
`define ACC_MODE_RSVD 2'h1
`define ACC_MODE_FALL 2'h2
`define ACC_MODE_RISE 2'h3
`define ACC_RST_BIT 1'h0
`define ACC_RST_MODE 2'h0
`define ACC_RST_STAT 2'h0
`define ACC_RST_CHAN 3'h0
`define ACC_RST_SYNC 2'h0
`define ACC_RST_DATA 32'h0000_0000
`endif

// ---- acc_pkg.sv ----
// types shared by the comparator control block
package acc_pkg;
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } acc_avs_req_s;
  typedef struct packed {
    logic use_mux;
    logic [2:0] channel;
  } acc_neg_sel_s;
  typedef enum logic [1:0] {
    ACC_BUS_IDLE = 2'b01,
    ACC_BUS_ANSWER = 2'b10
  } acc_bus_state_e;
endpackage
